// [hw/sms_pkg.sv]
// package: register map, field positions, reset values and state types for the spi controller
package sms_pkg;

  // ****************************************
  // register map (byte addresses on apb)
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_DATA    = 8'h08;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int CTL_IRQ_EN   = 7;
  localparam int CTL_PORT_EN  = 6;
  localparam int CTL_LSB_1ST  = 5;
  localparam int CTL_MASTER   = 4;
  localparam int CTL_CLOCK_POLARITY     = 3;
  localparam int CTL_CLOCK_PHASE     = 2;
  localparam int CTL_RATE_HI  = 1;
  localparam int CTL_RATE_LO  = 0;

  // ****************************************
  // status field positions and reset values
  // ****************************************
  localparam int STS_DONE     = 7;
  localparam int STS_WRITE_COLLISION_FLAG     = 6;
  localparam int STS_DBL      = 0;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam int BITS_PER_XFER = 8;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} sms_phase_e;

  typedef struct packed {
    logic       sck;
    logic       mosi;
    logic       mosi_oe;
    logic       miso;
    logic       miso_oe;
    logic       sck_oe;
  } sms_pins_s;

  typedef struct packed {
    logic [7:0] control;
    logic       done;
    logic       write_collision_flag;
    logic       dbl;
    logic [7:0] shift;
    logic [7:0] rx_buf;
    logic [3:0] bit_cnt;
    logic [6:0] div_cnt;
    sms_phase_e phase;
    logic       in_bit;
    logic       sck_prev;
    logic       armed;
    logic       irq;
    logic       pready;
    logic [31:0] prdata;
    sms_pins_s  pins;
  } sms_state_s;

endpackage

// [hw/sms_spi_ctrl.sv]
// spi master/slave controller with apb register access
// Function
// - interrupt request while done flag, irq enable and global enable all set
// - no spi activity unless port enable bit is one
// - bit order one shifts lsb first, zero shifts msb first
// - master select one gives master mode, zero slave mode
// - master with slave select configured as input and driven low clears master select, sets done flag
// - polarity one idles sck high, zero idles sck low
// - phase zero samples leading edge; phase one samples trailing edge
// - rate bits set sck only in master mode
// - divisors 4,16,64,128 or with double speed 2,8,32,64
// - done flag set when one byte transfer finishes
// - done flag cleared when interrupt vector is acknowledged
// - status read with done set then data access clears done
// - data write during transfer sets write collision flag
// - status read with collision set then data access clears both flags
// - status bits five to one read zero and ignore writes
// - double speed in master mode gives two-clock shortest sck period
// - data write loads shifter and starts master transfer
// - data read returns receive buffer, not live shifter
// - slave select high in slave mode resets bit count and phase, shifter keeps its value
// - transmit single buffered, receive buffer overwritten by next byte
`timescale 1ns/1ps
module sms_spi_ctrl
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  // cpu side
  input  wire logic        global_irq_en_in,
  input  wire logic        irq_ack_in,
  output logic             irq_out,
  // spi pins
  input  wire logic        ss_n_in,
  input  wire logic        ss_is_input_in,
  input  wire logic        sck_in,
  input  wire logic        mosi_in,
  input  wire logic        miso_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  output logic             mosi_out,
  output logic             mosi_oe_out,
  output logic             miso_out,
  output logic             miso_oe_out
);

  // ****************************************
  // state
  // ****************************************
  sms_pkg::sms_state_s s_q;
  sms_pkg::sms_state_s s_d;

  // half period of master sck in system clocks
  function automatic logic [6:0] half_div(input logic dbl, input logic [1:0] rate);
    logic [6:0] r;
    r = 7'h01;
    unique case (rate)
      2'b00: r = dbl ? 7'h01 : 7'h02;
      2'b01: r = dbl ? 7'h04 : 7'h08;
      2'b10: r = dbl ? 7'h10 : 7'h20;
      2'b11: r = dbl ? 7'h20 : 7'h40;
    endcase
    return r;
  endfunction

  function automatic logic out_bit(input logic lsb, input logic [7:0] sh);
    return lsb ? sh[0] : sh[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic lsb, input logic [7:0] sh, input logic b);
    return lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  logic apb_acc;
  logic en;
  logic master;
  logic lsb;
  logic clock_polarity;
  logic clock_phase;
  logic busy;
  logic sck_lead;
  logic sck_trail;
  logic lead_now;
  logic trail_now;
  logic [7:0] status_rd;
  logic       smp;

  assign apb_acc = psel_in && penable_in && s_q.pready;
  assign en      = s_q.control[sms_pkg::CTL_PORT_EN];
  assign master  = s_q.control[sms_pkg::CTL_MASTER];
  assign lsb     = s_q.control[sms_pkg::CTL_LSB_1ST];
  assign clock_polarity    = s_q.control[sms_pkg::CTL_CLOCK_POLARITY];
  assign clock_phase    = s_q.control[sms_pkg::CTL_CLOCK_PHASE];
  assign busy    = s_q.phase != sms_pkg::ST_IDLE;
  // reserved bits 5..1 are constant zero
  assign status_rd = {s_q.done, s_q.write_collision_flag, 5'h00, s_q.dbl};
  // slave edges from the raw pin; the master keeps sck slow enough
  assign sck_lead  = (sck_in != s_q.sck_prev) && (sck_in != clock_polarity);
  assign sck_trail = (sck_in != s_q.sck_prev) && (sck_in == clock_polarity);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    lead_now  = 1'b0;
    trail_now = 1'b0;
    smp       = 1'b0;
    s_d.sck_prev = sck_in;
    s_d.pready   = psel_in && !penable_in;

    // read word captured in setup so it stands together with pready
    if (psel_in && !penable_in && !pwrite_in)
    begin
      unique case (paddr_in)
        sms_pkg::ADDR_CONTROL: s_d.prdata = {24'h000000, s_q.control};
        sms_pkg::ADDR_STATUS:  s_d.prdata = {24'h000000, status_rd};
        sms_pkg::ADDR_DATA:    s_d.prdata = {24'h000000, s_q.rx_buf};
        default:               s_d.prdata = 32'h00000000;
      endcase
    end

    // apb
    if (apb_acc)
    begin
      // arm only if the word software saw carried a flag
      if (paddr_in == sms_pkg::ADDR_STATUS && !pwrite_in &&
          (s_q.prdata[sms_pkg::STS_DONE] || s_q.prdata[sms_pkg::STS_WRITE_COLLISION_FLAG]))
        s_d.armed = 1'b1;
      if (paddr_in == sms_pkg::ADDR_DATA && s_q.armed)
      begin
        s_d.done  = 1'b0;
        s_d.write_collision_flag  = 1'b0;
        s_d.armed = 1'b0;
      end
      if (pwrite_in && paddr_in == sms_pkg::ADDR_CONTROL)
        s_d.control = pwdata_in[7:0];
      if (pwrite_in && paddr_in == sms_pkg::ADDR_STATUS)
        s_d.dbl = pwdata_in[sms_pkg::STS_DBL];
      if (pwrite_in && paddr_in == sms_pkg::ADDR_DATA)
      begin
        if (busy)
          s_d.write_collision_flag = 1'b1;
        else
        begin
          s_d.shift   = pwdata_in[7:0];
          s_d.bit_cnt = 4'h0;
          if (en && master)
          begin
            s_d.phase   = sms_pkg::ST_LEAD;
            s_d.div_cnt = 7'h00;
          end
        end
      end
    end
    if (irq_ack_in)
      s_d.done = 1'b0;

    // shifting
    if (!en)
    begin
      s_d.phase   = sms_pkg::ST_IDLE;
      s_d.bit_cnt = 4'h0;
    end
    else if (master && ss_is_input_in && !ss_n_in)
    begin
      s_d.control[sms_pkg::CTL_MASTER] = 1'b0;
      s_d.phase = sms_pkg::ST_IDLE;
      s_d.done  = 1'b1;
      s_d.bit_cnt = 4'h0;
    end
    else if (master)
    begin
      if (busy)
      begin
        if (s_q.div_cnt + 7'h01 >= half_div(s_q.dbl, s_q.control[1:0]))
        begin
          s_d.div_cnt = 7'h00;
          if (s_q.phase == sms_pkg::ST_LEAD)
          begin
            lead_now = 1'b1;
            s_d.phase = sms_pkg::ST_TRAIL;
          end
          else
            trail_now = 1'b1;
        end
        else
          s_d.div_cnt = s_q.div_cnt + 7'h01;
      end
    end
    else if (ss_n_in)
    begin
      s_d.bit_cnt = 4'h0;
      s_d.phase   = sms_pkg::ST_IDLE;
    end
    else
    begin
      lead_now  = sck_lead;
      trail_now = sck_trail;
      if (lead_now && !busy)
        s_d.phase = sms_pkg::ST_TRAIL;
    end

    // data movement on edges
    if (lead_now)
    begin
      if (clock_phase)
        s_d.pins.mosi = out_bit(lsb, s_q.shift);
      else
        s_d.in_bit = master ? miso_in : mosi_in;
    end
    if (trail_now)
    begin
      smp = clock_phase ? (master ? miso_in : mosi_in) : s_q.in_bit;
      s_d.shift   = shift_in(lsb, s_q.shift, smp);
      s_d.bit_cnt = s_q.bit_cnt + 4'h1;
      if (master)
        s_d.phase = sms_pkg::ST_LEAD;
      if (s_q.bit_cnt == 4'(sms_pkg::BITS_PER_XFER - 1))
      begin
        s_d.rx_buf  = shift_in(lsb, s_q.shift, smp);
        s_d.done    = 1'b1;
        s_d.phase   = sms_pkg::ST_IDLE;
        s_d.bit_cnt = 4'h0;
      end
    end

    // pins
    s_d.pins.sck_oe  = en && master;
    s_d.pins.mosi_oe = en && master;
    s_d.pins.miso_oe = en && !master && !ss_n_in;
    if (!busy || !en || !master)
      s_d.pins.sck = clock_polarity;
    else if (lead_now)
      s_d.pins.sck = !clock_polarity;
    else if (trail_now)
      s_d.pins.sck = clock_polarity;
    // setup bit: first bit ready before leading edge when phase is zero
    if (!clock_phase && (!busy || trail_now))
    begin
      s_d.pins.mosi = out_bit(lsb, s_d.shift);
      s_d.pins.miso = out_bit(lsb, s_d.shift);
    end
    else if (clock_phase && lead_now)
      s_d.pins.miso = out_bit(lsb, s_q.shift);
    s_d.irq = s_d.done && s_d.control[sms_pkg::CTL_IRQ_EN] && global_irq_en_in;
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_q <= '0;
      s_q.control <= sms_pkg::CONTROL_RST;
    end
    else
      s_q <= s_d;
  end

  assign pready_out  = s_q.pready;
  assign prdata_out  = s_q.prdata;
  assign pslverr_out = 1'b0;
  assign irq_out     = s_q.irq;
  assign sck_out     = s_q.pins.sck;
  assign sck_oe_out  = s_q.pins.sck_oe;
  assign mosi_out    = s_q.pins.mosi;
  assign mosi_oe_out = s_q.pins.mosi_oe;
  assign miso_out    = s_q.pins.miso;
  assign miso_oe_out = s_q.pins.miso_oe;

  // ****************************************
  // assertions
  // ****************************************
  irq_gating_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    irq_out |-> $past(s_d.done && s_d.control[7])) else $error("irq without done");
  disabled_quiet_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !en |=> !busy) else $error("busy while disabled");
  mode_fault_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (en && master && ss_is_input_in && !ss_n_in) |=> (!master && s_q.done))
    else $error("mode fault not taken");
  irq_quiet_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !s_q.done |-> !irq_out) else $error("irq without flag");
  disabled_pins_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !en |=> (!sck_oe_out && !mosi_oe_out && !miso_oe_out)) else $error("pins driven");
  status_read_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !pwrite_in && paddr_in == sms_pkg::ADDR_STATUS)
    |=> (prdata_out[5:1] == 5'h00 && prdata_out[31:8] == 24'h000000))
    else $error("status reserved bits");
  unmapped_read_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !pwrite_in && paddr_in != sms_pkg::ADDR_CONTROL &&
     paddr_in != sms_pkg::ADDR_STATUS && paddr_in != sms_pkg::ADDR_DATA)
    |=> prdata_out == 32'h00000000) else $error("unmapped read");
  read_buffer_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !pwrite_in && paddr_in == sms_pkg::ADDR_DATA)
    |=> prdata_out[7:0] == $past(s_q.rx_buf)) else $error("data read source");
  clear_flags_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (apb_acc && paddr_in == sms_pkg::ADDR_DATA && s_q.armed && !(pwrite_in && busy))
    |=> !s_q.write_collision_flag) else $error("collision not cleared");
  clear_done_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (apb_acc && paddr_in == sms_pkg::ADDR_DATA && s_q.armed && !trail_now &&
     !(en && master && ss_is_input_in && !ss_n_in)) |=> !s_q.done)
    else $error("done not cleared");

  // ****************************************
  // assertions: shifting
  // ****************************************
  idle_level_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!busy && $past(!busy) && $stable(clock_polarity) && sck_oe_out) |-> sck_out == clock_polarity)
    else $error("sck idle level");
  master_pins_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (en && master) |=> (sck_oe_out && mosi_oe_out)) else $error("master pins off");
  rate_slave_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !master |=> $stable(s_q.div_cnt)) else $error("divider runs in slave");
  done_last_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (trail_now && s_q.bit_cnt == 4'(sms_pkg::BITS_PER_XFER - 1)) |=> s_q.done)
    else $error("done not set");
  ack_clear_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (irq_ack_in && !trail_now && !(en && master && ss_is_input_in && !ss_n_in))
    |=> !s_q.done) else $error("ack did not clear");
  load_start_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (apb_acc && pwrite_in && paddr_in == sms_pkg::ADDR_DATA && !busy && en && master &&
     !(ss_is_input_in && !ss_n_in)) |=> (busy && s_q.shift == $past(pwdata_in[7:0])))
    else $error("write did not start");
  slave_miso_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!master && ss_n_in) |=> !miso_oe_out) else $error("miso driven deselected");
  reserved_zero_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    status_rd[5:1] == 5'h00) else $error("reserved bits set");
  collision_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (apb_acc && pwrite_in && paddr_in == sms_pkg::ADDR_DATA && busy) |=> s_q.write_collision_flag)
    else $error("collision missed");
  fast_period_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (busy && master && s_q.dbl && s_q.control[1:0] == 2'b00 && lead_now) |=> trail_now)
    else $error("double speed period");
  slave_reset_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (en && !master && ss_n_in) |=> s_q.bit_cnt == 4'h0) else $error("slave not reset");
  eight_bits_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(s_q.done) && !$past(irq_ack_in) |-> s_q.bit_cnt == 4'h0) else $error("bit count");
  cov_master_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    master && $rose(s_q.done));
  cov_slave_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    !master && $rose(s_q.done));
  cov_write_collision_flag_c: cover property (@(posedge clock_in) disable iff (!rstn_in) $rose(s_q.write_collision_flag));
  cov_fault_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(master) && s_q.done);
  cov_slave_rst_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    en && !master && $rose(ss_n_in));

endmodule // sms_spi_ctrl

// [bench/sms_peer_model.sv]
// spi peer model: behavioural slave answering the controller in master mode
`timescale 1ns/1ps
module sms_peer_model
(
  // spi pins
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  // bench control: mode is {lsb first, clock_polarity, clock_phase}
  input  wire logic       sel_in,
  input  wire logic [2:0] mode_in,
  input  wire logic [7:0] tx_in,
  output logic [7:0]      rx_out
);
  logic [7:0] sh_q;
  logic       bit_w;
  int         n_q;
  initial
  begin
    sh_q = 8'h00;
    rx_out = 8'h00;
    n_q = 0;
  end
  always @(posedge sel_in)
  begin
    sh_q = tx_in;
    n_q = 0;
  end
  always @(sck_in)
  begin
    // leading edge leaves the idle level; no shift before the first sample
    if (sel_in && ((sck_in != mode_in[1]) ^ mode_in[0]))
    begin
      rx_out = mode_in[2] ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
      n_q++;
    end
    else if (sel_in && n_q != 0)
      sh_q = mode_in[2] ? sh_q >> 1 : sh_q << 1;
  end
  assign bit_w = mode_in[2] ? sh_q[0] : sh_q[7];
  // released line shows the inverse so a stale sample cannot pass
  assign miso_out = sel_in ? bit_w : ~bit_w;
endmodule // sms_peer_model

// [bench/spi_master_slave_controller_bench.sv]
// testbench for the spi controller: apb driver, peer model and scenarios
`timescale 1ns/1ps
module spi_master_slave_controller_bench;
  localparam logic [7:0] AC = sms_pkg::ADDR_CONTROL;
  localparam logic [7:0] AS = sms_pkg::ADDR_STATUS;
  localparam logic [7:0] AD = sms_pkg::ADDR_DATA;
  logic        clock_in, rstn_in, psel, penable, pwrite, gie, ack, ss_n, ss_in, sel, clr, sck_d;
  logic        ssck, smosi;
  wire         smiso;
  logic [7:0]  paddr, ptx;
  logic [31:0] pwdata, q;
  logic [2:0]  mode;
  wire         pready, irq, sck, sck_oe, mosi, miso;
  wire  [31:0] prdata;
  wire  [7:0]  prx;
  int          fail_count, total_checks, edges, t0, tl, cyc;

  sms_spi_ctrl u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(), .global_irq_en_in(gie),
    .irq_ack_in(ack), .irq_out(irq), .ss_n_in(ss_n), .ss_is_input_in(ss_in),
    .sck_in(ssck), .mosi_in(smosi), .miso_in(miso), .sck_out(sck), .sck_oe_out(sck_oe),
    .mosi_out(mosi), .mosi_oe_out(), .miso_out(smiso), .miso_oe_out());
  sms_peer_model u_peer (.sck_in(sck), .mosi_in(mosi), .miso_out(miso), .sel_in(sel),
    .mode_in(mode), .tx_in(ptx), .rx_out(prx));

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // sck rising edges counted against system clock cycles
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    sck_d <= sck;
    if (clr)
      edges <= 0;
    else if (sck && !sck_d)
    begin
      edges <= edges + 1;
      if (edges == 0)
        t0 <= cyc;
      tl <= cyc;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clock_in);
      n++;
    end
    if (pready !== 1'b1)
      fail_count++;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    q = 32'h0;
    while (q[7] !== 1'b1 && n < 400)
    begin
      apb(1'b0, AS, 32'h0);
      n++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(AC, 32'h0);
    apb(1'b1, AS, 32'hFF);
    rd(AS, 32'h01);
    apb(1'b1, 8'h10, 32'hFF);
    rd(8'h10, 32'h0);
    apb(1'b1, AC, 32'h10);
    apb(1'b1, AD, 32'h5A);
    repeat (40) @(posedge clock_in);
    chk(32'(sck_oe), 32'h0);
    rd(AS, 32'h01);
    $display("reset and disabled port test done");
  endtask
  task automatic t_modes();
    int         divs[4];
    logic [2:0] k;
    logic [7:0] d;
    divs = '{4, 16, 64, 128};
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      d = 8'hC5 ^ 8'(i * 19);
      sel <= 1'b0;
      ptx <= ~d;
      mode <= {k[2] ^ k[0], k[1], k[0]};
      clr <= 1'b1;
      apb(1'b1, AC, {24'h0, k[0], 1'b1, k[2] ^ k[0], 1'b1, k[1], k[0], k[1:0]});
      apb(1'b1, AS, {31'h0, k[2]});
      chk(32'(sck), 32'(k[1]));
      sel <= 1'b1;
      clr <= 1'b0;
      apb(1'b1, AD, {24'h0, d});
      wait_done();
      chk(32'(irq), 32'(k[0]));
      chk(edges, 8);
      chk(tl - t0, 7 * (divs[k[1:0]] >> k[2]));
      chk(32'(prx), 32'(d));
      if (k[0])
      begin
        ack <= 1'b1;
        @(posedge clock_in);
        ack <= 1'b0;
        @(posedge clock_in);
        rd(AS, {31'h0, k[2]});
      end
      rd(AD, {24'h0, ~d});
      rd(AS, {31'h0, k[2]});
      chk(32'(irq), 32'h0);
    end
    $display("mode, order and rate test done");
  endtask
  // slave side: bench acts as external master, twelve clocks per sck period
  task automatic s_bits(input logic [7:0] b, input logic [7:0] tx, input int n,
                        input logic ck);
    for (int i = 7; i > 7 - n; i--)
    begin
      smosi <= b[i];
      repeat (4) @(posedge clock_in);
      if (ck)
        chk(32'(smiso), 32'(tx[i]));
      ssck <= 1'b1;
      repeat (4) @(posedge clock_in);
      ssck <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
  endtask
  task automatic t_slave();
    apb(1'b1, AC, 32'h40);
    apb(1'b1, AD, 32'hA5);
    ss_n <= 1'b0;
    s_bits(8'h96, 8'hA5, 8, 1'b1);
    rd(AS, 32'h80);
    rd(AD, 32'h96);
    s_bits(8'hE1, 8'h00, 3, 1'b0);
    ss_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    ss_n <= 1'b0;
    s_bits(8'h3B, 8'h00, 8, 1'b0);
    rd(AS, 32'h80);
    rd(AD, 32'h3B);
    ss_n <= 1'b1;
    $display("slave mode test done");
  endtask
  task automatic t_collide();
    sel <= 1'b0;
    mode <= 3'b000;
    apb(1'b1, AC, 32'h53);
    apb(1'b1, AS, 32'h0);
    sel <= 1'b1;
    apb(1'b1, AD, 32'h3C);
    apb(1'b1, AD, 32'hFF);
    rd(AS, 32'h40);
    apb(1'b0, AD, 32'h0);
    rd(AS, 32'h0);
    wait_done();
    apb(1'b0, AD, 32'h0);
    chk(32'(prx), 32'h3C);
    $display("write collision test done");
  endtask
  task automatic t_fault();
    apb(1'b1, AC, 32'h50);
    ss_in <= 1'b1;
    ss_n <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(AC, 32'h40);
    rd(AS, 32'h80);
    chk(32'(sck_oe), 32'h0);
    ss_n <= 1'b1;
    apb(1'b0, AD, 32'h0);
    $display("mode fault test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, ack, ss_in, sel, clr, sck_d, ssck, smosi} = '0;
    {paddr, ptx, pwdata, mode} = '0;
    {cyc, edges, t0, tl, fail_count, total_checks} = '0;
    {gie, ss_n} = 2'b11;
    rstn_in = 1'b0;
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_modes();
    t_collide();
    t_slave();
    t_fault();
    print_verdict();
  end
  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule // spi_master_slave_controller_bench
